// *** common/mif_map.vh ***
// Register map, field positions and reset values of the interrupt flag block
`ifndef MIF_MAP_VH
`define MIF_MAP_VH

// Register addresses and address width
`define MIF_ADDR_W          10
`define MIF_ADDR_FLAGS      10'h004
`define MIF_ADDR_MASK       10'h006

// Register width, reset values and implemented-bit mask
`define MIF_REG_W           16
`define MIF_FLAGS_RESET     16'h0000
`define MIF_MASK_RESET      16'h0000
`define MIF_IMPL_BITS       16'hFF0F

// Flag bit positions
`define MIF_BIT_OVERRUN     15
`define MIF_BIT_DONE        14
`define MIF_BIT_REACT_DIR   13
`define MIF_BIT_REAL_DIR    12
`define MIF_BIT_ZX_MISS     11
`define MIF_BIT_LOW_V       10
`define MIF_BIT_HIGH_V      9
`define MIF_BIT_HIGH_I      8
`define MIF_BIT_VSUM        3
`define MIF_BIT_ACC_OVF     2
`define MIF_BIT_CSUM        1
`define MIF_BIT_SUPPLY      0

`endif

// *** src/mif_chan_mon.v ***
// Per-voltage-channel monitor over one processing cycle
`default_nettype none

module mif_chan_mon #(
    parameter W = 16
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst,
    // Cycle framing
    input  wire         cycle_start,
    input  wire         cycle_done,
    // Samples
    input  wire         sample_valid,
    input  wire [W-1:0] sample,
    input  wire         zero_cross,
    // Thresholds
    input  wire [W-1:0] low_thr,
    input  wire [W-1:0] high_thr,
    // Events; zx_missing and low_trip are one-cycle pulses, high_trip stays high while samples exceed high_thr
    output reg          zx_missing,
    output reg          low_trip,
    output reg          high_trip
);

    reg          zx_seen_reg;
    reg          above_low_reg;
    wire [W-1:0] abs_val;
    wire         hit_low;

    // Most negative code wraps to itself; still reads as large
    assign abs_val = sample[W-1] ? (~sample + {{(W-1){1'b0}}, 1'b1}) : sample;
    assign hit_low = sample_valid && (abs_val > low_thr);

    always @(posedge clk) begin
        if (rst) begin
            zx_seen_reg   <= 1'b0;
            above_low_reg <= 1'b0;
            zx_missing    <= 1'b0;
            low_trip      <= 1'b0;
            high_trip     <= 1'b0;
        end else begin
            // R6 missing zero crossing
            zx_missing <= cycle_done && !(zx_seen_reg || zero_cross);
            // R7 never above low
            low_trip   <= cycle_done && !(above_low_reg || hit_low);
            // R8 above high threshold
            high_trip  <= sample_valid && (abs_val > high_thr);
            if (cycle_start || cycle_done) begin
                zx_seen_reg   <= 1'b0;
                above_low_reg <= 1'b0;
            end else begin
                if (zero_cross)
                    zx_seen_reg <= 1'b1;
                if (hit_low)
                    above_low_reg <= 1'b1;
            end
        end
    end

endmodule // mif_chan_mon

`default_nettype wire

// *** src/mif_flags.v ***
// Interrupt request flag and mask registers with event detection
//
// Behaviour
// R1 - Bit 15 sets when a new processing cycle starts before the previous one finished.
// R2 - On overrun the host should slow the sample rate or disable fundamental calculations.
// R3 - Bit 14 sets each time a processing cycle completes.
// R4 - Bit 13 sets when the reactive energy direction reverses.
// R5 - Bit 12 sets when the real energy direction reverses.
// R6 - Bit 11 sets when a voltage channel sees no zero crossing in a whole cycle.
// R7 - Bit 10 sets when a voltage channel never exceeds the low threshold in a cycle.
// R8 - Bit 9 sets when any voltage channel magnitude exceeds the high voltage threshold.
// R9 - Bit 8 sets when any current channel magnitude exceeds the high current threshold.
// R10 - Bit 3 sets when the current vector sum exceeds its threshold.
// R11 - Bit 2 sets when any energy accumulator overflows its top bit.
// R12 - Bit 1 sets whenever the configuration checksum changes value.
// R13 - The host should examine any checksum change before trusting the metering.
// R14 - Bit 0 sets when supply failure is imminent.
// R15 - The host clears each serviced flag, else the interrupt keeps asserting.
// R16 - A flag drives the active-low interrupt only while its mask bit is set.
// R17 - Bits 7 to 4 read as zero and ignore writes.
`include "mif_map.vh"
`default_nettype none

module mif_flags #(
    parameter W  = 16,
    parameter NV = 3,
    parameter NI = 4
) (
    // Clock and reset
    input  wire                   CLOCK,
    input  wire                   SYS_RST,
    // Register access from the serial port decoder
    input  wire [`MIF_ADDR_W-1:0] REG_ADDR,
    input  wire                   REG_WR,
    input  wire [`MIF_REG_W-1:0]  REG_WDATA,
    input  wire                   REG_RD,
    output reg  [`MIF_REG_W-1:0]  REG_RDATA,
    output reg                    REG_RVALID,
    // Processing cycle framing
    input  wire                   CYCLE_START,
    input  wire                   CYCLE_DONE,
    // Energy direction, sampled at cycle completion
    input  wire                   REAL_ENERGY_NEG,
    input  wire                   REACT_ENERGY_NEG,
    // Instantaneous samples, signed, packed per channel
    input  wire                   SAMPLE_VALID,
    input  wire [NV*W-1:0]        VOLT_SAMPLE,
    input  wire [NV-1:0]          VOLT_ZERO_CROSS,
    input  wire [NI*W-1:0]        CURR_SAMPLE,
    input  wire [W-1:0]           CURR_VECTOR_SUM,
    // Thresholds
    input  wire [W-1:0]           LOW_VOLTAGE_THRESHOLD,
    input  wire [W-1:0]           HIGH_VOLTAGE_THRESHOLD,
    input  wire [W-1:0]           HIGH_CURRENT_THRESHOLD,
    input  wire [W-1:0]           VECTOR_SUM_THRESHOLD,
    // Accumulator overflow pulses and checksum
    input  wire                   ACCUM_OVERFLOW,
    input  wire                   CONFIG_CHECKSUM_VALID,
    input  wire [`MIF_REG_W-1:0]  CONFIG_CHECKSUM,
    // Supply monitor pin, asynchronous
    input  wire                   SUPPLY_FAIL_PIN,
    // Interrupt request, active low
    output reg                    IRQ_N
);

    reg  [`MIF_REG_W-1:0] interrupt_request_flags_reg;
    reg  [`MIF_REG_W-1:0] interrupt_request_flags_next;
    reg  [`MIF_REG_W-1:0] interrupt_mask_reg;
    reg  [`MIF_REG_W-1:0] event_vec;
    reg  [`MIF_REG_W-1:0] clear_vec;
    reg                   busy_reg;
    reg                   real_neg_reg;
    reg                   react_neg_reg;
    reg                   dir_valid_reg;
    reg  [`MIF_REG_W-1:0] csum_reg;
    reg                   csum_valid_reg;
    reg                   supply_meta_reg;
    reg                   supply_sync_reg;
    reg                   high_i_reg;
    reg                   vsum_reg;
    wire [NV-1:0]         zx_missing;
    wire [NV-1:0]         low_trip;
    wire [NV-1:0]         high_trip;
    wire [NI-1:0]         curr_over;

    genvar g;
    generate
        for (g = 0; g < NV; g = g + 1) begin : g_volt
            mif_chan_mon #(
                .W            (W)
            ) u_mon (
                .clk          (CLOCK),
                .rst          (SYS_RST),
                .cycle_start  (CYCLE_START),
                .cycle_done   (CYCLE_DONE),
                .sample_valid (SAMPLE_VALID),
                .sample       (VOLT_SAMPLE[g*W +: W]),
                .zero_cross   (VOLT_ZERO_CROSS[g]),
                .low_thr      (LOW_VOLTAGE_THRESHOLD),
                .high_thr     (HIGH_VOLTAGE_THRESHOLD),
                .zx_missing   (zx_missing[g]),
                .low_trip     (low_trip[g]),
                .high_trip    (high_trip[g])
            );
        end
        for (g = 0; g < NI; g = g + 1) begin : g_curr
            wire [W-1:0] s = CURR_SAMPLE[g*W +: W];
            wire [W-1:0] a = s[W-1] ? (~s + {{(W-1){1'b0}}, 1'b1}) : s;
            // R9 current magnitude compare
            assign curr_over[g] = SAMPLE_VALID && (a > HIGH_CURRENT_THRESHOLD);
        end
    endgenerate

    // Register timing: current, vector sum, supply and voltage channel sources are registered; other events come straight from the inputs
    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            busy_reg        <= 1'b0;
            real_neg_reg    <= 1'b0;
            react_neg_reg   <= 1'b0;
            dir_valid_reg   <= 1'b0;
            csum_reg        <= `MIF_FLAGS_RESET;
            csum_valid_reg  <= 1'b0;
            supply_meta_reg <= 1'b0;
            supply_sync_reg <= 1'b0;
            high_i_reg      <= 1'b0;
            vsum_reg        <= 1'b0;
        end else begin
            if (CYCLE_START)
                busy_reg <= 1'b1;
            else if (CYCLE_DONE)
                busy_reg <= 1'b0;
            if (CYCLE_DONE) begin
                real_neg_reg  <= REAL_ENERGY_NEG;
                react_neg_reg <= REACT_ENERGY_NEG;
                dir_valid_reg <= 1'b1;
            end
            if (CONFIG_CHECKSUM_VALID) begin
                csum_reg       <= CONFIG_CHECKSUM;
                csum_valid_reg <= 1'b1;
            end
            // Pin is asynchronous; two stages before use
            supply_meta_reg <= SUPPLY_FAIL_PIN;
            supply_sync_reg <= supply_meta_reg;
            high_i_reg      <= |curr_over;
            // R10 vector sum compare
            vsum_reg        <= SAMPLE_VALID && (CURR_VECTOR_SUM > VECTOR_SUM_THRESHOLD);
        end
    end

    always @* begin
        event_vec = {`MIF_REG_W{1'b0}};
        // R1 start while still busy
        event_vec[`MIF_BIT_OVERRUN]   = CYCLE_START && busy_reg && !CYCLE_DONE;
        // R3 cycle complete
        event_vec[`MIF_BIT_DONE]      = CYCLE_DONE;
        // R4 reactive direction change
        event_vec[`MIF_BIT_REACT_DIR] = CYCLE_DONE && dir_valid_reg &&
                                        (REACT_ENERGY_NEG != react_neg_reg);
        // R5 real direction change
        event_vec[`MIF_BIT_REAL_DIR]  = CYCLE_DONE && dir_valid_reg &&
                                        (REAL_ENERGY_NEG != real_neg_reg);
        // R6 any channel without crossing
        event_vec[`MIF_BIT_ZX_MISS]   = |zx_missing;
        // R7 any channel stayed low
        event_vec[`MIF_BIT_LOW_V]     = |low_trip;
        // R8 any channel too high
        event_vec[`MIF_BIT_HIGH_V]    = |high_trip;
        // R9 any current too high
        event_vec[`MIF_BIT_HIGH_I]    = high_i_reg;
        // R10 vector sum excess
        event_vec[`MIF_BIT_VSUM]      = vsum_reg;
        // R11 accumulator overflow
        event_vec[`MIF_BIT_ACC_OVF]   = ACCUM_OVERFLOW;
        // R12 checksum changed
        event_vec[`MIF_BIT_CSUM]      = CONFIG_CHECKSUM_VALID && csum_valid_reg &&
                                        (CONFIG_CHECKSUM != csum_reg);
        // R14 supply failing, level keeps re-setting
        event_vec[`MIF_BIT_SUPPLY]    = supply_sync_reg;
    end

    always @* begin
        clear_vec = {`MIF_REG_W{1'b0}};
        // R15 write one to clear
        if (REG_WR && (REG_ADDR == `MIF_ADDR_FLAGS))
            clear_vec = REG_WDATA;
        // R17 reserved bits never hold state; set beats clear
        interrupt_request_flags_next = ((interrupt_request_flags_reg & ~clear_vec) | event_vec)
                                       & `MIF_IMPL_BITS;
    end

    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            interrupt_request_flags_reg <= `MIF_FLAGS_RESET;
            interrupt_mask_reg          <= `MIF_MASK_RESET;
            REG_RDATA                   <= {`MIF_REG_W{1'b0}};
            REG_RVALID                  <= 1'b0;
            IRQ_N                       <= 1'b1;
        end else begin
            interrupt_request_flags_reg <= interrupt_request_flags_next;
            // R17 reserved mask bits ignore writes
            if (REG_WR && (REG_ADDR == `MIF_ADDR_MASK))
                interrupt_mask_reg <= REG_WDATA & `MIF_IMPL_BITS;
            REG_RVALID <= REG_RD;
            if (REG_RD) begin
                case (REG_ADDR)
                    `MIF_ADDR_FLAGS: REG_RDATA <= interrupt_request_flags_reg;
                    `MIF_ADDR_MASK:  REG_RDATA <= interrupt_mask_reg;
                    default:         REG_RDATA <= {`MIF_REG_W{1'b0}};
                endcase
            end
            // R16 masked flags drive request
            IRQ_N <= ~|(interrupt_request_flags_reg & interrupt_mask_reg);
        end
    end

endmodule // mif_flags

`default_nettype wire

// *** verif/mif_flags_assertions.sv ***
// Port-level assertions for the interrupt flag block
`include "mif_map.vh"
`default_nettype none
module mif_flags_assertions (
    // Clock and reset
    input wire logic                   CLOCK,
    input wire logic                   SYS_RST,
    // Register port
    input wire logic [`MIF_ADDR_W-1:0] REG_ADDR,
    input wire logic                   REG_WR,
    input wire logic [15:0]            REG_WDATA,
    input wire logic                   REG_RD,
    input wire logic [15:0]            REG_RDATA,
    input wire logic                   REG_RVALID,
    // Events and interrupt
    input wire logic                   CYCLE_DONE,
    input wire logic                   IRQ_N
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mask_q;
    wire         mwr = REG_WR && REG_ADDR == `MIF_ADDR_MASK;
    // Shadow of the mask so interrupt timing can be judged
    always @(posedge CLOCK) begin
        if (SYS_RST) mask_q <= 16'h0000;
        else if (mwr) mask_q <= REG_WDATA & `MIF_IMPL_BITS;
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    sequence rd_flags;
        REG_RD && REG_ADDR == `MIF_ADDR_FLAGS;
    endsequence
    sequence clr_done;
        REG_WR && REG_ADDR == `MIF_ADDR_FLAGS && REG_WDATA[14] && !CYCLE_DONE;
    endsequence
    answer_one_a: assert property (REG_RD |=> REG_RVALID)
        else $error("read answer missing");
    answer_pulse_a: assert property (!REG_RD |=> !REG_RVALID)
        else $error("read answer without read");
    data_hold_a: assert property (!REG_RVALID |-> $stable(REG_RDATA))
        else $error("read data moved without a read");
    reserved_zero_a: assert property (REG_RVALID |-> REG_RDATA[7:4] == 4'h0)
        else $error("reserved bits read nonzero");
    unmapped_zero_a: assert property (REG_RD && REG_ADDR != `MIF_ADDR_FLAGS
        && REG_ADDR != `MIF_ADDR_MASK |=> REG_RDATA == 16'h0000)
        else $error("unmapped read nonzero");
    done_flag_a: assert property (CYCLE_DONE ##1 rd_flags |=> REG_RDATA[14])
        else $error("done flag not set");
    clear_flag_a: assert property (clr_done ##1 !CYCLE_DONE ##1 rd_flags |=> !REG_RDATA[14])
        else $error("flag not cleared");
    irq_raise_a: assert property (CYCLE_DONE && mask_q[14] && !mwr |=> ##1 !IRQ_N)
        else $error("interrupt not raised");
    irq_quiet_a: assert property (mwr && REG_WDATA == 16'h0000 |=> ##1 IRQ_N)
        else $error("interrupt active while masked");
endmodule // mif_flags_assertions
bind mif_flags mif_flags_assertions chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .CYCLE_DONE(CYCLE_DONE), .IRQ_N(IRQ_N));
`default_nettype wire

// *** verif/mif_host.sv ***
// Host model driving the register port of the flag block
`default_nettype none
module mif_host (
    // Clock
    input  wire logic        clk,
    // Register port
    output var  logic [9:0]  addr,
    output var  logic        wr,
    output var  logic [15:0] wdata,
    output var  logic        rd,
    input  wire logic [15:0] rdata,
    input  wire logic        rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr = 10'h3FF;
        wr = 1'b0;
        wdata = 16'hFFFF;
        rd = 1'b0;
    end
    task automatic wr_reg(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk);
        #1 addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk);
        #1 wr = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask
    task automatic rd_reg(input logic [9:0] a, output logic [15:0] d, output logic v);
        @(posedge clk);
        #1 addr = a;
        rd = 1'b1;
        @(posedge clk);
        #1 rd = 1'b0;
        addr = ~a;
        d = rdata;
        v = rvalid;
    endtask
endmodule // mif_host
`default_nettype wire

// *** verif/test_metering_interrupt_flags.sv ***
// Self-checking bench for the interrupt flag block
`include "mif_map.vh"
`default_nettype none
module test_metering_interrupt_flags;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, c_start, c_done, re_neg, rx_neg, s_valid, acc, cs_v, sup;
    logic        wr, rd, rvalid, irq_n, ok;
    logic [2:0]  zx;
    logic [9:0]  addr;
    logic [15:0] vsum, cs, wdata, rdata, got;
    logic [47:0] volt;
    logic [63:0] curr;
    int          mismatches, n_checks;
    int          cycles = 0;
    mif_flags dut (.CLOCK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WR(wr),
        .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
        .CYCLE_START(c_start), .CYCLE_DONE(c_done), .REAL_ENERGY_NEG(re_neg),
        .REACT_ENERGY_NEG(rx_neg), .SAMPLE_VALID(s_valid), .VOLT_SAMPLE(volt),
        .VOLT_ZERO_CROSS(zx), .CURR_SAMPLE(curr), .CURR_VECTOR_SUM(vsum),
        .LOW_VOLTAGE_THRESHOLD(16'h0080), .HIGH_VOLTAGE_THRESHOLD(16'h4000),
        .HIGH_CURRENT_THRESHOLD(16'h4000), .VECTOR_SUM_THRESHOLD(16'h4000),
        .ACCUM_OVERFLOW(acc), .CONFIG_CHECKSUM_VALID(cs_v), .CONFIG_CHECKSUM(cs),
        .SUPPLY_FAIL_PIN(sup), .IRQ_N(irq_n));
    mif_host host (.clk(clk), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd),
        .rdata(rdata), .rvalid(rvalid));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Generous ceiling; the sequence needs about 130 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic done_pulse();
        c_done = 1'b1;
        step(1);
        c_done = 1'b0;
    endtask
    // Read flags after settling, compare, then clear them all
    task automatic flags(input logic [15:0] exp);
        step(3);
        host.rd_reg(`MIF_ADDR_FLAGS, got, ok);
        chk("rvalid", 16'h0001, {15'h0000, ok});
        chk("flags", exp, got);
        host.wr_reg(`MIF_ADDR_FLAGS, 16'hFFFF);
    endtask
    task automatic t_reset();
        host.rd_reg(`MIF_ADDR_FLAGS, got, ok);
        chk("flags reset", `MIF_FLAGS_RESET, got);
        host.rd_reg(`MIF_ADDR_MASK, got, ok);
        chk("mask reset", `MIF_MASK_RESET, got);
        host.rd_reg(10'h3FF, got, ok);
        chk("unmapped", 16'h0000, got);
        chk("irq idle", 16'h0001, {15'h0000, irq_n});
        host.wr_reg(`MIF_ADDR_MASK, 16'h0000);
    endtask
    task automatic t_dir();
        done_pulse();
        flags(16'h4000);
        re_neg = 1'b1;
        done_pulse();
        flags(16'h5000);
        rx_neg = 1'b1;
        done_pulse();
        flags(16'h6000);
    endtask
    task automatic t_irq();
        host.wr_reg(`MIF_ADDR_MASK, 16'h4000);
        c_done = 1'b1;
        // Done stands one edge; the read goes out on the next edge
        fork
            host.rd_reg(`MIF_ADDR_FLAGS, got, ok);
            begin
                step(1);
                c_done = 1'b0;
            end
        join
        chk("done read", 16'h4000, got);
        step(2);
        chk("irq on", 16'h0000, {15'h0000, irq_n});
        host.wr_reg(`MIF_ADDR_FLAGS, 16'h4000);
        host.rd_reg(`MIF_ADDR_FLAGS, got, ok);
        chk("cleared", 16'h0000, got);
        step(2);
        chk("irq off", 16'h0001, {15'h0000, irq_n});
        host.wr_reg(`MIF_ADDR_MASK, 16'h0000);
    endtask
    task automatic t_events();
        c_start = 1'b1;
        step(2);
        c_start = 1'b0;
        done_pulse();
        flags(16'hC000);
        c_start = 1'b1;
        step(1);
        c_start = 1'b0;
        done_pulse();
        flags(16'h4000);
        volt[31:16] = 16'hB000;
        curr[63:48] = 16'h4001;
        vsum = 16'h4001;
        step(1);
        volt[31:16] = 16'h0100;
        curr = '0;
        vsum = '0;
        flags(16'h0308);
        zx = 3'b101;
        volt[15:0] = 16'h0040;
        step(1);
        c_start = 1'b1;
        step(1);
        c_start = 1'b0;
        done_pulse();
        zx = 3'b111;
        volt[15:0] = 16'h0100;
        flags(16'h4C00);
    endtask
    task automatic t_misc();
        acc = 1'b1;
        step(1);
        acc = 1'b0;
        flags(16'h0004);
        cs = 16'h1234;
        cs_v = 1'b1;
        step(2);
        cs = 16'h5678;
        step(1);
        cs_v = 1'b0;
        flags(16'h0002);
        sup = 1'b1;
        step(4);
        sup = 1'b0;
        flags(16'h0001);
        host.wr_reg(`MIF_ADDR_MASK, 16'hFFFF);
        host.rd_reg(`MIF_ADDR_MASK, got, ok);
        chk("mask bits", `MIF_IMPL_BITS, got);
        host.wr_reg(`MIF_ADDR_MASK, 16'h0000);
    endtask
    initial begin
        {rst, c_start, c_done, re_neg, rx_neg, acc, cs_v, sup} = 8'h80;
        s_valid = 1'b1;
        zx = 3'b111;
        volt = {3{16'h0100}};
        curr = '0;
        vsum = '0;
        cs = '0;
        mismatches = 0;
        n_checks = 0;
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        t_reset();
        t_dir();
        t_irq();
        t_events();
        t_misc();
        end_sim();
    end
endmodule // test_metering_interrupt_flags
`default_nettype wire
